/* File: rtl/amp_fault_pkg.sv */
package amp_fault_pkg;
// ==========================================================================
// Contract
// - Latching faults and clock errors drive the open-drain fault pin low, else released.
// - Latching faults hold the pin low until shutdown toggles and recovery ends.
// - Non-latching faults except clock errors leave the pin; playback auto-resumes.
// - Clock errors pull the pin low and recover with no recovery wait.
// - Over-voltage is non-latching, no pin, clears when supply flag drops.
// - Under-voltage is non-latching, no pin, clears when supply flag returns.
// - Bad clock ratio, bad clock rate or stopped clock raises clock error; ratio and rate are only checked in hardware mode.
// - Over-current latches; clears after recovery time and shutdown toggle.
// - DC detect latches; clears after recovery time and shutdown toggle.
// - Over-temperature latches; clear also needs the die below hysteresis.
// - DC event when a channel duty stays above 60% one polarity >420 ms.
// - Shutdown input low shuts the amplifier down, high brings it out.
// - Hardware mode uses defaults, changed only through the control pins.
// - Static pins tied low select bridge-tied load and 768 kHz switching.
// - Hardware mode accepts I2S only, single speed, limited clock rates.
// - Bit clock must be 32, 48 or 64 times the frame rate.
// - Master clock ratio limits depend on the sample rate band.
// - A latching fault still present after shutdown release is caught again.

  // ========================================================================
  // Timing
  localparam int CLK_KHZ = 200000;
  localparam int CYC_PER_MS = CLK_KHZ * 1;
  localparam int DC_DETECT_MS = 420;
  localparam int FAULT_RECOVERY_MS = 1;
  localparam logic [15:0] STOP_FAST_CYC = 16'h0400;
  localparam logic [15:0] STOP_FRAME_CYC = 16'h8000;

  // ========================================================================
  // Frame period bands in core cycles and accepted clock ratios
  localparam logic [15:0] P12_MIN = 16'h3a98;
  localparam logic [15:0] P12_MAX = 16'h4650;
  localparam logic [15:0] P16_MIN = 16'h2cec;
  localparam logic [15:0] P16_MAX = 16'h34bc;
  localparam logic [15:0] P24_MIN = 16'h1e78;
  localparam logic [15:0] P24_MAX = 16'h2328;
  localparam logic [15:0] P48_MIN = 16'h0f3c;
  localparam logic [15:0] P48_MAX = 16'h19c8;
  localparam logic [9:0] MCLK_128 = 10'h080;
  localparam logic [9:0] MCLK_192 = 10'h0c0;
  localparam logic [9:0] MCLK_256 = 10'h100;
  localparam logic [9:0] MCLK_384 = 10'h180;
  localparam logic [9:0] MCLK_512 = 10'h200;
  localparam logic [9:0] SCLK_32 = 10'h020;
  localparam logic [9:0] SCLK_48 = 10'h030;
  localparam logic [9:0] SCLK_64 = 10'h040;

  // ========================================================================
  // Registers
  localparam int REG_AW = 4;
  localparam int REG_DW = 8;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] CTRL_MASK = 8'h0f;
  localparam int CTRL_SD_N = 0;
  localparam int CTRL_SLEEP = 1;
  localparam int CTRL_PBTL = 2;
  localparam int CTRL_FREQ_X8 = 3;
  localparam int STS_OV = 0;
  localparam int STS_UV = 1;
  localparam int STS_CLK = 2;
  localparam int STS_OC = 3;
  localparam int STS_DC = 4;
  localparam int STS_OT = 5;
  localparam int STS_PIN = 6;
  localparam int STS_HW = 7;
  localparam int LAT_OC = 0;
  localparam int LAT_DC = 1;
  localparam int LAT_OT = 2;

  typedef enum logic [2:0] {
    RATE_NONE, RATE_12K, RATE_16K, RATE_24K, RATE_32_48K
  } rate_t;
  typedef enum logic [1:0] {ST_OFF, ST_RECOVER, ST_RUN} amp_state_t;
endpackage

/* File: rtl/clk_check_if.sv */
`timescale 1ns/1ps
interface clk_check_if;
  logic clk_err;
  logic ratio_bad;
  logic stopped;
  modport src (output clk_err, output ratio_bad, output stopped);
  modport dst (input clk_err, input ratio_bad, input stopped);
endinterface

/* File: rtl/clk_ratio_checker.sv */
`timescale 1ns/1ps
module clk_ratio_checker (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic mclk_in,
  input wire logic sclk_in,
  input wire logic lrck_in,
  input wire logic hw_mode_in,
  clk_check_if.src chk_if
);
  import amp_fault_pkg::*;

  // ========================================================================
  // Edge finding on the three audio clocks
  logic [2:0] sync1_ff, sync2_ff, prev_ff;
  logic [15:0] per_cnt_ff;
  logic [9:0] mclk_cnt_ff, sclk_cnt_ff;
  logic [15:0] idle_ff [3];
  logic bad_ff, err_ff;
  wire [2:0] rise_w = sync2_ff & ~prev_ff;
  wire frame_w = rise_w[2];
  wire [2:0] stop_w;

  // A tolerance of one edge absorbs sampling jitter at frame boundaries.
  function automatic logic near(input logic [9:0] v, input logic [9:0] t);
    return (v + 10'h001 >= t) && (v <= t + 10'h001);
  endfunction

  function automatic rate_t rate_of(input logic [15:0] p);
    if (p >= P12_MIN && p <= P12_MAX) return RATE_12K;
    if (p >= P16_MIN && p <= P16_MAX) return RATE_16K;
    if (p >= P24_MIN && p <= P24_MAX) return RATE_24K;
    if (p >= P48_MIN && p <= P48_MAX) return RATE_32_48K;
    return RATE_NONE;
  endfunction

  function automatic logic mclk_ok(input rate_t r, input logic [9:0] m);
    logic n128, n192, n256, n384, n512;
    n128 = near(m, MCLK_128);
    n192 = near(m, MCLK_192);
    n256 = near(m, MCLK_256);
    n384 = near(m, MCLK_384);
    n512 = near(m, MCLK_512);
    case (r)
      RATE_12K: return n512;
      RATE_16K: return n256 | n384 | n512;
      RATE_24K: return n192 | n256 | n384 | n512;
      RATE_32_48K: return n128 | n192 | n256 | n384 | n512;
      default: return 1'b0;
    endcase
  endfunction

  wire [9:0] mclk_tot_w = mclk_cnt_ff + {9'h000, rise_w[0]};
  wire [9:0] sclk_tot_w = sclk_cnt_ff + {9'h000, rise_w[1]};
  wire sclk_good_w = near(sclk_tot_w, SCLK_32) | near(sclk_tot_w, SCLK_48) |
                     near(sclk_tot_w, SCLK_64);
  wire mclk_good_w = mclk_ok(rate_of(per_cnt_ff), mclk_tot_w);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      prev_ff <= 3'h0;
    end else begin
      sync1_ff <= {lrck_in, sclk_in, mclk_in};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // Edges are counted per frame clock period.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || frame_w) begin
      per_cnt_ff <= 16'h0001;
      mclk_cnt_ff <= 10'h000;
      sclk_cnt_ff <= 10'h000;
    end else begin
      per_cnt_ff <= (per_cnt_ff == 16'hffff) ? per_cnt_ff : per_cnt_ff + 16'h1;
      mclk_cnt_ff <= mclk_tot_w;
      sclk_cnt_ff <= sclk_tot_w;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_idle
      always_ff @(posedge core_clk_in) begin
        if (sys_rst_in || rise_w[i]) begin
          idle_ff[i] <= 16'h0000;
        end else if (idle_ff[i] != 16'hffff) begin
          idle_ff[i] <= idle_ff[i] + 16'h0001;
        end
      end
      assign stop_w[i] = idle_ff[i] >= ((i == 2) ? STOP_FRAME_CYC :
                                        STOP_FAST_CYC);
    end
  endgenerate

  // Ratio limits only hold in hardware mode, where single speed applies.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !hw_mode_in) begin
      bad_ff <= 1'b0;
    end else if (frame_w) begin
      bad_ff <= !(mclk_good_w && sclk_good_w);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= bad_ff | (|stop_w);
    end
  end

  assign chk_if.clk_err = err_ff;
  assign chk_if.ratio_bad = bad_ff;
  assign chk_if.stopped = |stop_w;

  // ========================================================================
  // Checks
  stop_err_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $rose(|stop_w) |=> chk_if.clk_err)
    else $error("stopped clock did not raise clock error");
  rate12_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    frame_w && hw_mode_in && rate_of(per_cnt_ff) == RATE_12K &&
    !near(mclk_tot_w, MCLK_512) |=> ##1 chk_if.clk_err)
    else $error("bad master ratio at 12 kHz accepted");
  sclk_ratio_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    frame_w && hw_mode_in && !sclk_good_w |=> bad_ff)
    else $error("bad bit clock ratio accepted");
endmodule

/* File: rtl/amp_fault_ctrl.sv */
`timescale 1ns/1ps
module amp_fault_ctrl #(
  parameter int MS_DIV_CYCLES = amp_fault_pkg::CYC_PER_MS,
  parameter int RECOVERY_MS = amp_fault_pkg::FAULT_RECOVERY_MS
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic mclk_in,
  input wire logic sclk_in,
  input wire logic lrck_in,
  input wire logic amp_shutdown_n_in,
  input wire logic sleep_or_addr_pin_in,
  input wire logic parallel_load_pin_in,
  input wire logic freq_pin_in,
  input wire logic [1:0] spk_gain_in,
  input wire logic ov_flag_in,
  input wire logic uv_flag_in,
  input wire logic oc_flag_in,
  input wire logic ot_flag_in,
  input wire logic ot_cool_in,
  input wire logic [1:0] duty_pos_in,
  input wire logic [1:0] duty_neg_in,
  input wire logic amp_fault_n_in,
  output logic amp_fault_n_out,
  output logic amp_fault_oe_out,
  output logic amp_run_out,
  output logic amp_sleep_out,
  output logic cfg_hw_mode_out,
  output logic cfg_pbtl_out,
  output logic cfg_freq_x8_out,
  output logic cfg_i2s_only_out,
  input wire logic [amp_fault_pkg::REG_AW-1:0] reg_addr_in,
  input wire logic [amp_fault_pkg::REG_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [amp_fault_pkg::REG_DW-1:0] reg_rdata_out
);
  import amp_fault_pkg::*;

  // ========================================================================
  // Pin synchronisers
  localparam int NSYNC = 16;
  localparam logic [17:0] MS_LAST = 18'(MS_DIV_CYCLES - 1);
  localparam logic [7:0] REC_LAST = 8'(RECOVERY_MS - 1);
  localparam logic [9:0] DC_LIMIT = 10'(DC_DETECT_MS);

  logic [NSYNC-1:0] meta_ff, sync_ff;
  wire [NSYNC-1:0] async_w = {amp_fault_n_in, duty_neg_in, duty_pos_in,
    ot_cool_in, ot_flag_in, oc_flag_in, uv_flag_in, ov_flag_in, spk_gain_in,
    freq_pin_in, parallel_load_pin_in, sleep_or_addr_pin_in,
    amp_shutdown_n_in};

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_w;
      sync_ff <= meta_ff;
    end
  end

  wire sd_pin_w = sync_ff[0];
  wire sleep_pin_w = sync_ff[1];
  wire pbtl_pin_w = sync_ff[2];
  wire freq_pin_w = sync_ff[3];
  wire [1:0] gain_w = sync_ff[5:4];
  wire ov_w = sync_ff[6];
  wire uv_w = sync_ff[7];
  wire oc_w = sync_ff[8];
  wire ot_w = sync_ff[9];
  wire cool_w = sync_ff[10];
  wire [1:0] dpos_w = sync_ff[12:11];
  wire [1:0] dneg_w = sync_ff[14:13];
  wire pin_lvl_w = sync_ff[15];

  // ========================================================================
  // Control mode and configuration
  logic [7:0] ctrl_ff;
  logic [7:0] rdata_ff;
  logic [7:0] status_w;
  // Both gain pins high hand control to software.
  wire hw_mode_w = (gain_w != 2'b11);
  wire sd_eff_w = sd_pin_w & (hw_mode_w | ctrl_ff[CTRL_SD_N]);
  // In software mode the sleep pin is an address strap, so the bit rules.
  wire sleep_eff_w = hw_mode_w ? sleep_pin_w : ctrl_ff[CTRL_SLEEP];
  // Pins tied low give bridge-tied load and 16x, 768 kHz at 48 kHz.
  wire pbtl_w = hw_mode_w ? pbtl_pin_w : ctrl_ff[CTRL_PBTL];
  wire freq_x8_w = hw_mode_w ? freq_pin_w : ctrl_ff[CTRL_FREQ_X8];

  clk_check_if chk ();

  clk_ratio_checker u_chk (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .mclk_in(mclk_in),
    .sclk_in(sclk_in),
    .lrck_in(lrck_in),
    .hw_mode_in(hw_mode_w),
    .chk_if(chk.src)
  );

  wire clk_err_w = chk.clk_err;

  // ========================================================================
  // Millisecond tick and power state
  amp_state_t state_ff, nxt_state;
  logic [17:0] ms_cnt_ff;
  logic [7:0] rec_cnt_ff;
  // The divider restarts in shutdown so recovery is never cut short.
  wire ms_tick_w = (ms_cnt_ff == MS_LAST);
  wire rec_done_w = (state_ff == ST_RECOVER) && ms_tick_w &&
                    (rec_cnt_ff == REC_LAST);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || state_ff == ST_OFF || ms_tick_w) begin
      ms_cnt_ff <= 18'h00000;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + 18'h00001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || state_ff != ST_RECOVER) begin
      rec_cnt_ff <= 8'h00;
    end else if (ms_tick_w) begin
      rec_cnt_ff <= rec_cnt_ff + 8'h01;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF: begin
        if (sd_eff_w) begin
          nxt_state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (!sd_eff_w) begin
          nxt_state = ST_OFF;
        end else if (rec_done_w) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!sd_eff_w) begin
          nxt_state = ST_OFF;
        end
      end
      default: nxt_state = ST_OFF;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ========================================================================
  // DC detection per channel
  logic [9:0] dc_cnt_ff [2];
  logic [1:0] dc_pol_ff;
  wire [1:0] dc_hit_w;

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_dc
      wire act_w = dpos_w[c] ^ dneg_w[c];
      always_ff @(posedge core_clk_in) begin
        if (sys_rst_in || state_ff != ST_RUN || !act_w) begin
          dc_cnt_ff[c] <= 10'h000;
          dc_pol_ff[c] <= 1'b0;
        end else if (dc_pol_ff[c] != dpos_w[c]) begin
          dc_cnt_ff[c] <= 10'h000;
          dc_pol_ff[c] <= dpos_w[c];
        end else if (ms_tick_w && !dc_hit_w[c]) begin
          dc_cnt_ff[c] <= dc_cnt_ff[c] + 10'h001;
        end
      end
      assign dc_hit_w[c] = (dc_cnt_ff[c] > DC_LIMIT);
    end
  endgenerate

  // ========================================================================
  // Latching faults
  logic [2:0] lat_ff;
  wire live_w = (state_ff != ST_OFF);
  // Detection runs again from shutdown release, so a lasting fault returns.
  wire [2:0] lat_evt_w = {ot_w, |dc_hit_w, oc_w} & {3{live_w}};
  // Over-temperature also waits for the die to cool below hysteresis.
  wire [2:0] lat_clr_w = {cool_w, 2'b11} & {3{rec_done_w}};
  // A new event wins over a clear in the same cycle.
  wire [2:0] nxt_lat = lat_evt_w | (lat_ff & ~lat_clr_w);
  // Over- and under-voltage only hold off playback; clock errors also drive the pin.
  wire fault_w = (|lat_ff) | clk_err_w;
  wire nxt_run = (state_ff == ST_RUN) && !(|lat_ff) && !clk_err_w &&
                 !ov_w && !uv_w && !sleep_eff_w;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      lat_ff <= 3'h0;
      amp_fault_oe_out <= 1'b0;
      amp_run_out <= 1'b0;
      amp_sleep_out <= 1'b0;
    end else begin
      lat_ff <= nxt_lat;
      amp_fault_oe_out <= fault_w;
      amp_run_out <= nxt_run;
      amp_sleep_out <= sleep_eff_w;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cfg_hw_mode_out <= 1'b1;
      cfg_pbtl_out <= 1'b0;
      cfg_freq_x8_out <= 1'b0;
      cfg_i2s_only_out <= 1'b1;
    end else begin
      cfg_hw_mode_out <= hw_mode_w;
      cfg_pbtl_out <= pbtl_w;
      cfg_freq_x8_out <= freq_x8_w;
      cfg_i2s_only_out <= hw_mode_w;
    end
  end

  // The pin only ever sinks; the pull-up sits outside.
  assign amp_fault_n_out = 1'b0;

  // ========================================================================
  // Register port
  assign status_w[STS_OV] = ov_w;
  assign status_w[STS_UV] = uv_w;
  assign status_w[STS_CLK] = clk_err_w;
  assign status_w[STS_OC] = lat_ff[LAT_OC];
  assign status_w[STS_DC] = lat_ff[LAT_DC];
  assign status_w[STS_OT] = lat_ff[LAT_OT];
  assign status_w[STS_PIN] = pin_lvl_w;
  assign status_w[STS_HW] = hw_mode_w;

  wire [7:0] rd_mux_w = (reg_addr_in == REG_CTRL) ? ctrl_ff :
                        (reg_addr_in == REG_STATUS) ? status_w : 8'h00;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl_ff <= CTRL_RST;
    end else if (reg_wr_in && reg_addr_in == REG_CTRL) begin
      ctrl_ff <= reg_wdata_in & CTRL_MASK;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd_in ? rd_mux_w : 8'h00;
    end
  end

  assign reg_rdata_out = rdata_ff;

  // ========================================================================
  // Checks
  default clocking dc_cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  fault_pin_a: assert property (fault_w |=> amp_fault_oe_out)
    else $error("fault not shown on pin");
  latch_hold_a: assert property (
    $fell(|lat_ff) |-> $past(rec_done_w))
    else $error("latched fault cleared without recovery");
  quiet_a: assert property (
    (ov_w || uv_w) && lat_ff == 3'h0 && !clk_err_w |=> !amp_fault_oe_out)
    else $error("supply fault drove fault pin");
  clk_resume_a: assert property (
    state_ff == ST_RUN && lat_ff == 3'h0 && !ov_w && !uv_w &&
    !sleep_eff_w && $fell(clk_err_w) |=> amp_run_out)
    else $error("no automatic resume after clock error");
  ov_mute_a: assert property (ov_w |=> !amp_run_out)
    else $error("played during over-voltage");
  uv_mute_a: assert property (uv_w |=> !amp_run_out)
    else $error("played during under-voltage");
  oc_latch_a: assert property (oc_w && live_w |=> lat_ff[LAT_OC])
    else $error("over-current not latched");
  dc_latch_a: assert property (
    dc_hit_w != 2'b00 && live_w |=> lat_ff[LAT_DC])
    else $error("dc detect not latched");
  ot_hold_a: assert property (
    lat_ff[LAT_OT] && !cool_w |=> lat_ff[LAT_OT])
    else $error("hot die cleared over-temperature");
  dc_time_a: assert property (
    $rose(dc_hit_w[0]) |-> $past(ms_tick_w) && state_ff == ST_RUN)
    else $error("dc detect outside a tick");
  sd_off_a: assert property (!sd_eff_w |=> ##1 !amp_run_out)
    else $error("played in shutdown");
  rec_wait_a: assert property (
    state_ff == ST_OFF ##1 state_ff == ST_RECOVER |-> ##1
    state_ff != ST_RUN)
    else $error("recovery skipped");
  reappear_a: assert property (
    state_ff == ST_RECOVER && oc_w |=> lat_ff[LAT_OC])
    else $error("fault not caught after release");
  clk_src_a: assert property (
    chk.stopped | chk.ratio_bad |=> clk_err_w)
    else $error("clock check result lost");

  run_c: cover property (state_ff == ST_RECOVER ##1 state_ff == ST_RUN);
  latch_clear_c: cover property ($fell(|lat_ff));
  clk_err_c: cover property ($rose(clk_err_w));
  dc_c: cover property ($rose(|dc_hit_w));
endmodule

/* File: tb/audio_host_model.sv */
`timescale 1ns/1ps
// ==========================================
// Host clock source with settable ratios.
module audio_host_model (
  input wire logic run_in,
  input wire logic [9:0] mratio_in,
  input wire logic [9:0] sratio_in,
  output logic mclk_out,
  output logic sclk_out,
  output logic lrck_out
);
  int pos;
  // Stopped clocks stand still, so the stop detector sees no edge at all.
  initial begin
    mclk_out = 1'b0;
    sclk_out = 1'b0;
    lrck_out = 1'b0;
    pos = 0;
    forever begin
      #32;
      if (run_in) begin
        mclk_out = ~mclk_out;
        if (!mclk_out) begin
          pos = (pos + 1) % mratio_in;
          sclk_out = 1'(((pos * 2 * sratio_in) / mratio_in) % 2);
          lrck_out = (pos >= mratio_in / 2);
        end
      end
    end
  end
endmodule

/* File: tb/tb_amp_fault_ctrl.sv */
`timescale 1ns/1ps
module tb_amp_fault_ctrl;
  import amp_fault_pkg::*;
  localparam int MSD = 20;
  localparam int REC = 2;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic sd_n = 1'b1, sleep = 1'b0, pl = 1'b0, fq = 1'b0;
  logic [1:0] gain = 2'b00, dpos = 2'b00, dneg = 2'b00;
  logic ov = 1'b0, uv = 1'b0, oc = 1'b0, ot = 1'b0, cool = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, rd_d = 1'b0, e_hw = 1'b1, clk_run = 1'b1;
  logic e_sl = 1'b0;
  logic [1:0] e_cf = 2'b00;
  logic oe, fault_n, run, hw, pbtl, fx8, slp, i2s, mclk, sclk, lrck;
  logic [7:0] rdata;
  logic [9:0] mr = MCLK_384, sr = SCLK_64;
  int errors = 0, num_checks = 0, seed = 82;
  logic [14:0] notes[$];
  wire [14:0] seen_w = {oe, run, hw, pbtl, fx8, slp, i2s, rdata};
  // The fault net has a pull-up, so it is high unless the block pulls it.
  wire fault_net = oe ? fault_n : 1'b1;

  audio_host_model audio_host_model_inst (.run_in(clk_run), .mratio_in(mr),
    .sratio_in(sr), .mclk_out(mclk), .sclk_out(sclk), .lrck_out(lrck));

  amp_fault_ctrl #(.MS_DIV_CYCLES(MSD), .RECOVERY_MS(REC)) amp_fault_ctrl_inst (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .mclk_in(mclk),
    .sclk_in(sclk), .lrck_in(lrck), .amp_shutdown_n_in(sd_n),
    .sleep_or_addr_pin_in(sleep), .parallel_load_pin_in(pl),
    .freq_pin_in(fq), .spk_gain_in(gain), .ov_flag_in(ov), .uv_flag_in(uv),
    .oc_flag_in(oc), .ot_flag_in(ot), .ot_cool_in(cool),
    .duty_pos_in(dpos), .duty_neg_in(dneg), .amp_fault_n_in(fault_net),
    .amp_fault_n_out(fault_n), .amp_fault_oe_out(oe), .amp_run_out(run),
    .amp_sleep_out(slp), .cfg_hw_mode_out(hw), .cfg_pbtl_out(pbtl),
    .cfg_freq_x8_out(fx8), .cfg_i2s_only_out(i2s), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata));

  // ==========================================
  // Clock and shared tasks.
  initial begin
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic o, input logic r,
                        input logic [7:0] d);
    @(posedge core_clk_in);
    notes.push_back({o, r, e_hw, e_hw ? pl : e_cf[0], e_hw ? fq : e_cf[1],
                     e_sl, e_hw, d});
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
  endtask

  task automatic st(input logic o, input logic r, input logic [5:0] b);
    rd_reg(REG_STATUS, o, r, {e_hw, ~o, b});
  endtask

  task automatic cycle_sd;
    sleep <= 1'b1;
    tick(4);
    sd_n <= 1'b0;
    tick(8);
    sd_n <= 1'b1;
    sleep <= 1'b0;
    tick(REC * MSD + 10);
  endtask

  // Read data stand only in the cycle after the strobe.
  always @(posedge core_clk_in) begin
    rd_d <= rd;
    if (rd_d) begin
      check(seen_w, notes.pop_front());
    end
  end

  // ==========================================
  // Scenarios.
  initial begin
    tick(16);
    sys_rst_in <= 1'b0;
    pl <= 1'($random(seed));
    fq <= 1'($random(seed));
    tick(11000);
    st(1'b0, 1'b1, 6'h00);
    for (int i = 0; i < 2; i++) begin
      {uv, ov} <= 2'(1 << i);
      tick(6);
      st(1'b0, 1'b0, 6'(1 << i));
      {uv, ov} <= 2'b00;
      tick(6);
      st(1'b0, 1'b1, 6'h00);
    end
    oc <= 1'b1;
    tick(6);
    oc <= 1'b0;
    tick(4);
    st(1'b1, 1'b0, 6'h08);
    oc <= 1'b1;
    cycle_sd();
    st(1'b1, 1'b0, 6'h08);
    oc <= 1'b0;
    cycle_sd();
    st(1'b0, 1'b1, 6'h00);
    ot <= 1'b1;
    cool <= 1'b0;
    tick(6);
    ot <= 1'b0;
    cycle_sd();
    st(1'b1, 1'b0, 6'h20);
    cool <= 1'b1;
    cycle_sd();
    st(1'b0, 1'b1, 6'h00);
    dpos <= 2'b01;
    tick(400 * MSD);
    st(1'b0, 1'b1, 6'h00);
    dpos <= 2'b00;
    dneg <= 2'b01;
    tick(30 * MSD);
    st(1'b0, 1'b1, 6'h00);
    tick(400 * MSD);
    st(1'b1, 1'b0, 6'h10);
    dneg <= 2'b00;
    cycle_sd();
    st(1'b0, 1'b1, 6'h00);
    clk_run <= 1'b0;
    tick(1100);
    st(1'b1, 1'b0, 6'h04);
    clk_run <= 1'b1;
    tick(11000);
    st(1'b0, 1'b1, 6'h00);
    sr <= 10'h060;
    tick(11000);
    st(1'b1, 1'b0, 6'h04);
    sr <= SCLK_64;
    mr <= MCLK_256;
    tick(11000);
    st(1'b1, 1'b0, 6'h04);
    mr <= MCLK_384;
    tick(11000);
    st(1'b0, 1'b1, 6'h00);
    gain <= 2'b11;
    e_hw <= 1'b0;
    tick(6);
    rd_reg(REG_CTRL, 1'b0, 1'b1, CTRL_RST);
    wr_reg(REG_CTRL, 8'h00);
    tick(4);
    st(1'b0, 1'b0, 6'h00);
    rd_reg(4'h5, 1'b0, 1'b0, 8'h00);
    wr_reg(REG_CTRL, 8'hf1);
    tick(REC * MSD + 10);
    rd_reg(REG_CTRL, 1'b0, 1'b1, 8'h01);
    wr_reg(REG_CTRL, 8'h0f);
    e_sl <= 1'b1;
    e_cf <= 2'b11;
    tick(4);
    rd_reg(REG_CTRL, 1'b0, 1'b0, 8'h0f);
    tick(4);
    results();
  end

  // A hang is cut short well after the planned run ends.
  initial begin
    tick(90000);
    errors++;
    results();
  end
endmodule
